// >>> bench/sac_host_model.sv
/*
 * host model for the serial side of the attenuator control port.
 * assumes go is raised for one core clock edge, then held low until busy falls.
 */
`timescale 1ns/1ns

module sac_host_model (
	input  wire logic       i_clk,      // core clock, paces requests
	input  wire logic       i_go,       // start a frame
	input  wire logic [7:0] i_word,     // bits to send, msb first
	input  wire logic [3:0] i_nbits,    // bits in this frame
	output logic            o_busy,     // frame in progress
	output logic            o_ser_clk,  // serial clock, still between frames
	output logic            o_ser_data  // serial data
);
	// ------------------------------------------------------------------
	// frame sender
	// ------------------------------------------------------------------
	// link clock runs only inside a frame, 125 ns, off the core phase
	initial begin
		o_busy = 1'b0;
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_busy = 1'b1;
				#7;
				for (int i = int'(i_nbits) - 1; i >= 0; i--) begin
					o_ser_data = i_word[i];
					#62;
					o_ser_clk = 1'b1;
					#63;
					o_ser_clk = 1'b0;
				end
				#20;
				// released line shows the inverse so stale data is never trusted
				o_ser_data = ~o_ser_data;
				o_busy = 1'b0;
			end
		end
	end
endmodule // sac_host_model

// >>> bench/tb_top.sv
/*
 * self-checking bench for the attenuator control port.
 * assumes the host model drives the serial pins and the bench the rest.
 */
`timescale 1ns/1ns

module tb_top;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic              clk;       // core clock
	logic              rst_b;     // power-up reset
	logic              sel;       // interface select
	logic [4:0]        pins;      // parallel word, 16 db first
	logic              gate;      // capture gate level
	logic              gate_en;   // gate driven by host
	logic [1:0]        pre;       // presets {b, a}
	logic              go;        // frame request
	logic [7:0]        word;      // frame bits
	logic [3:0]        nbits;     // frame length
	logic              busy;      // frame running
	logic              sclk;      // serial clock
	logic              sdata;     // serial data
	sac_pkg::sac_att_t atten;     // applied word
	sac_pkg::sac_sr_t  sword;     // serial word copy
	logic              ready;     // power-up done
	logic              fast;      // too-fast flag
	int                num_errors;
	int                n_compared;
	sac_pkg::sac_att_t preset_tbl [4] = '{5'h00, 5'h10, 5'h08, 5'h1f};

	always #5 clk = ~clk;

	sac_top uut (
		.i_clk                  (clk),
		.i_rst_b                (rst_b),
		.i_interface_select     (sel),
		.i_weight_sixteen_db    (pins[4]),
		.i_weight_eight_db      (pins[3]),
		.i_weight_four_db       (pins[2]),
		.i_weight_two_db        (pins[1]),
		.i_weight_one_db        (pins[0]),
		.i_word_capture_gate    (gate),
		.i_word_capture_gate_en (gate_en),
		.i_startup_preset_sel_a (pre[0]),
		.i_startup_preset_sel_b (pre[1]),
		.i_ser_clk              (sclk),
		.i_ser_data             (sdata),
		.o_atten                (atten),
		.o_serial_word          (sword),
		.o_ready                (ready),
		.o_fast_update          (fast)
	);

	sac_host_model host (
		.i_clk      (clk),
		.i_go       (go),
		.i_word     (word),
		.i_nbits    (nbits),
		.o_busy     (busy),
		.o_ser_clk  (sclk),
		.o_ser_data (sdata)
	);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic give_verdict;
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// compares sample at the falling edge, where outputs have settled
	task automatic chk_att(input sac_pkg::sac_att_t exp);
		@(negedge clk);
		n_compared++;
		if (atten !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, atten, exp);
		end
	endtask

	task automatic chk_word(input sac_pkg::sac_sr_t exp);
		@(negedge clk);
		n_compared++;
		if (sword !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, sword, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		@(negedge clk);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// pins held through reset so the power-up load sees stable levels
	task automatic power_up(input logic s, input logic g, input logic [4:0] p,
		input logic [1:0] pr);
		int k;
		@(posedge clk);
		rst_b <= 1'b0;
		sel <= s;
		gate <= g;
		pins <= p;
		pre <= pr;
		tick(4);
		rst_b <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(negedge clk);
			if (ready === 1'b1) break;
		end
		if (k == 20) begin
			num_errors++;
			give_verdict();
		end
	endtask

	task automatic send(input logic [7:0] w, input logic [3:0] n);
		int k;
		@(posedge clk);
		word <= w;
		nbits <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (k = 0; k < 400; k++) begin
			@(posedge clk);
			if (busy === 1'b0) break;
		end
		if (k == 400) begin
			num_errors++;
			give_verdict();
		end
		tick(8);
	endtask

	task automatic pulse_gate;
		tick(1);
		gate <= 1'b1;
		tick(4);
		gate <= 1'b0;
		tick(5);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		sel = 1'b0;
		pins = 5'h00;
		gate = 1'b0;
		gate_en = 1'b1;
		pre = 2'h0;
		go = 1'b0;
		word = 8'h00;
		nbits = 4'h0;
		num_errors = 0;
		n_compared = 0;
		// every preset code in latched parallel mode
		for (int c = 0; c < 4; c++) begin
			power_up(1'b0, 1'b0, 5'h15, 2'(c));
			chk_att(preset_tbl[c]);
		end
		power_up(1'b0, 1'b1, 5'h0b, 2'h3);
		chk_att(5'h0b);
		// direct mode, each weight alone, changes back to back
		for (int i = 0; i < 5; i++) begin
			tick(1);
			pins <= 5'h01 << i;
			tick(5);
			chk_att(5'h01 << i);
		end
		chk_bit(fast, 1'b1);
		tick(4100);
		pins <= 5'h1f;
		tick(5);
		chk_att(5'h1f);
		chk_bit(fast, 1'b0);
		// undriven gate reads high although the host level is low
		tick(1);
		gate_en <= 1'b0;
		gate <= 1'b0;
		pins <= 5'h0e;
		tick(5);
		chk_att(5'h0e);
		// latched: gate low first, then new bits, then a pulse
		tick(1);
		gate_en <= 1'b1;
		tick(4);
		pins <= 5'h05;
		tick(10);
		chk_att(5'h0e);
		pulse_gate();
		chk_att(5'h05);
		// serial power-up from pin levels
		power_up(1'b1, 1'b0, 5'h15, 2'h0);
		chk_att(5'h15);
		chk_word(6'h2a);
		chk_bit(ready, 1'b1);
		// flush frame lets the link reset synchroniser fill first
		send(8'h00, 4'h8);
		send(8'h26, 4'h6);
		chk_word(6'h26);
		chk_att(5'h15);
		pulse_gate();
		chk_att(5'h13);
		tick(1);
		gate <= 1'b1;
		pins <= 5'h0a;
		tick(6);
		chk_att(5'h13);
		send(8'h3e, 4'h6);
		chk_att(5'h1f);
		tick(1);
		gate <= 1'b0;
		tick(4);
		send(8'h02, 4'h6);
		chk_word(6'h02);
		chk_att(5'h1f);
		give_verdict();
	end
endmodule // tb_top

// >>> design/sac_link_if.sv
/*
 * carrier between the serial shift module and the core.
 * assumes sr_word changes only together with tog, on the link clock.
 */
`timescale 1ns/1ns
`include "sac_regs.svh"

interface sac_link_if;
	logic [`SAC_SR_W-1:0] sr_word;  // shift register contents
	logic                 tog;      // flips on each shift

	modport link_side (output sr_word, output tog);
	modport core_side (input sr_word, input tog);
endinterface

// >>> design/sac_pkg.sv
/*
 * types of the step attenuator control port.
 * assumes sac_regs.svh is on the include path.
 */
`include "sac_regs.svh"

package sac_pkg;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef logic [`SAC_ATTEN_W-1:0] sac_att_t;   // attenuation word
	typedef logic [`SAC_SR_W-1:0]    sac_sr_t;    // serial word
	typedef logic [`SAC_GAP_W-1:0]   sac_gap_t;   // update gap count

	typedef enum logic {
		SAC_SETTLE,                               // after reset, pins filling
		SAC_RUN                                   // normal operation
	} sac_state_e;

	// core domain state
	typedef struct packed {
		sac_state_e state;                        // top state
		logic [1:0] settle_cnt;                   // settle counter
		sac_att_t   par_s1;                       // parallel pins, stage 1
		sac_att_t   par_s2;                       // parallel pins, stage 2
		logic       gate_s1;                      // capture gate, stage 1
		logic       gate_s2;                      // capture gate, stage 2
		logic       sel_s1;                       // interface select, stage 1
		logic       sel_s2;                       // interface select, stage 2
		logic [1:0] pre_s1;                       // preset selects, stage 1
		logic [1:0] pre_s2;                       // preset selects, stage 2
		logic       tog_t1;                       // shift toggle, stage 1
		logic       tog_t2;                       // shift toggle, stage 2
		logic       tog_t3;                       // shift toggle, edge ref
		sac_sr_t    ser_word;                     // serial word in core domain
		sac_att_t   atten;                        // applied attenuation
		sac_gap_t   gap;                          // cycles since last change
		logic       fast;                         // last change came too soon
		logic       run;                          // operating flag
	} sac_core_s;

	// link domain state
	typedef struct packed {
		logic    rst_s1;                          // reset sync, stage 1
		logic    rst_s2;                          // reset sync, stage 2
		sac_sr_t sr;                              // shift register
		logic    tog;                             // flips on every shift
	} sac_link_s;

endpackage

// >>> design/sac_regs.svh
/*
 * constants of the step attenuator control port: widths, field positions,
 * preset words and timing counts.
 * assumes a 100 mhz core clock and is included by its bare name.
 */
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ----------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------
`define SAC_ATTEN_W      5          // attenuation word width
`define SAC_SR_W         6          // serial shift register width
`define SAC_SR_EO_BIT    0          // trailing zero bit position
`define SAC_SR_ATT_HI    5          // msb of attenuation field in shift word
`define SAC_SR_ATT_LO    1          // lsb of attenuation field in shift word

// ----------------------------------------------------------------------
// power-up preset words, index {sel_b, sel_a}
// ----------------------------------------------------------------------
`define SAC_PRESET_00    5'h00      // reference loss
`define SAC_PRESET_B     5'h08      // 8 db
`define SAC_PRESET_A     5'h10      // 16 db
`define SAC_PRESET_AB    5'h1f      // 31 db
`define SAC_EO_ZERO      1'h0       // trailing bit value

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SAC_SETTLE_CYC   2'h3       // cycles for pin synchronisers to fill
`define SAC_CLK_HZ       100000000  // core clock rate
`define SAC_UPDATE_HZ    25000      // fastest allowed state update rate
`define SAC_UPDATE_CYC   12'((`SAC_CLK_HZ + `SAC_UPDATE_HZ - 1) / `SAC_UPDATE_HZ)
`define SAC_GAP_W        12         // width of update gap counter

`endif

// >>> design/sac_shift.sv
/*
 * serial-in parallel-out shift register on the serial clock.
 * assumes the serial clock is slow against the core clock and may stop.
 */
`timescale 1ns/1ns
`include "sac_regs.svh"

module sac_shift (
	input  wire logic         i_ser_clk,   // serial clock from host
	input  wire logic         i_ser_data,  // serial data from host
	input  wire logic         i_rst_b,     // core reset, async to this domain
	sac_link_if.link_side     link         // word and toggle to the core
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	sac_pkg::sac_link_s st_r;   // registered state
	sac_pkg::sac_link_s st_nxt; // next state
	logic               lrst_b; // synchronised reset

	assign lrst_b = st_r.rst_s2;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// shifting ignores the capture gate entirely
	always_comb begin
		st_nxt        = st_r;
		st_nxt.rst_s1 = i_rst_b;
		st_nxt.rst_s2 = st_r.rst_s1;
		if (lrst_b) begin
			// msb first: 16 db bit ends on top, trailing bit at bit 0
			st_nxt.sr  = {st_r.sr[`SAC_SR_W-2:0], i_ser_data};
			st_nxt.tog = ~st_r.tog;
		end else begin
			st_nxt.sr  = '0;
			st_nxt.tog = 1'h0;
		end
	end

	// reset flops take no reset: they carry it
	always_ff @(posedge i_ser_clk) begin
		st_r <= st_nxt;
	end

	assign link.sr_word = st_r.sr;
	assign link.tog     = st_r.tog;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_shift_in;
		@(posedge i_ser_clk) disable iff (!lrst_b)
		lrst_b |=> st_r.sr == {$past(st_r.sr[`SAC_SR_W-2:0]), $past(i_ser_data)};
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("shift register did not advance by one");

	property p_tog_flip;
		@(posedge i_ser_clk) disable iff (!lrst_b)
		lrst_b |=> st_r.tog != $past(st_r.tog);
	endproperty
	a_tog_flip: assert property (p_tog_flip)
		else $error("toggle did not flip on a shift");

endmodule // sac_shift

// >>> design/sac_top.sv
/*
 * control port of a 5-bit step attenuator: parallel and serial word
 * paths, capture gate, power-up presets and an update rate monitor.
 * assumes host pins are asynchronous and the serial clock is its own
 * domain with a period of at least five core cycles.
 */
`timescale 1ns/1ns
`include "sac_regs.svh"

module sac_top (
	input  wire logic                    i_clk,                  // core clock, 100 mhz
	input  wire logic                    i_rst_b,                // sync reset, power-up
	input  wire logic                    i_interface_select,     // 0 parallel, 1 serial
	input  wire logic                    i_weight_sixteen_db,    // parallel 16 db bit
	input  wire logic                    i_weight_eight_db,      // parallel 8 db bit
	input  wire logic                    i_weight_four_db,       // parallel 4 db bit
	input  wire logic                    i_weight_two_db,        // parallel 2 db bit
	input  wire logic                    i_weight_one_db,        // parallel 1 db bit
	input  wire logic                    i_word_capture_gate,    // capture gate level
	input  wire logic                    i_word_capture_gate_en, // host drives the gate
	input  wire logic                    i_startup_preset_sel_a, // preset select a
	input  wire logic                    i_startup_preset_sel_b, // preset select b
	input  wire logic                    i_ser_clk,              // serial clock
	input  wire logic                    i_ser_data,             // serial data
	output logic [`SAC_ATTEN_W-1:0]      o_atten,                // applied attenuation
	output logic [`SAC_SR_W-1:0]         o_serial_word,          // serial word, core copy
	output logic                         o_ready,                // power-up done
	output logic                         o_fast_update           // last change too soon
);

	// ------------------------------------------------------------------
	// serial path
	// ------------------------------------------------------------------
	sac_link_if link ();  // word and toggle from the link domain

	sac_shift u_shift (
		.i_ser_clk  (i_ser_clk),
		.i_ser_data (i_ser_data),
		.i_rst_b    (i_rst_b),
		.link       (link.link_side)
	);

	// ------------------------------------------------------------------
	// state and helpers
	// ------------------------------------------------------------------
	sac_pkg::sac_core_s st_r;       // registered state
	sac_pkg::sac_core_s st_nxt;     // next state
	logic               gate_pin;   // gate level after pull-up
	logic               tog_edge;   // a new serial word arrived
	logic               settle_end; // last settle cycle
	sac_pkg::sac_att_t  preset;     // decoded preset word
	sac_pkg::sac_att_t  src;        // selected source word
	sac_pkg::sac_att_t  par_word;   // raw parallel pins

	// an undriven gate floats high through the pull-up
	assign gate_pin = i_word_capture_gate_en ? i_word_capture_gate : 1'h1;

	// weights ordered msb 16 db down to lsb 1 db, so the value is the sum
	assign par_word = {i_weight_sixteen_db, i_weight_eight_db, i_weight_four_db,
		i_weight_two_db, i_weight_one_db};

	// t2 is the first stable stage, t3 the reference for edges
	assign tog_edge   = st_r.tog_t2 ^ st_r.tog_t3;
	assign settle_end = (st_r.state == sac_pkg::SAC_SETTLE) &&
		(st_r.settle_cnt == `SAC_SETTLE_CYC);

	// ------------------------------------------------------------------
	// preset decode
	// ------------------------------------------------------------------
	// index is {sel_b, sel_a}
	always_comb begin
		case (st_r.pre_s2)
			2'h0:    preset = `SAC_PRESET_00;
			2'h2:    preset = `SAC_PRESET_B;
			2'h1:    preset = `SAC_PRESET_A;
			2'h3:    preset = `SAC_PRESET_AB;
			default: preset = `SAC_PRESET_00;
		endcase
	end

	// ------------------------------------------------------------------
	// source select
	// ------------------------------------------------------------------
	// the serial word's trailing bit is never applied to the attenuator;
	// a host that leaves it set only wastes that bit
	always_comb begin
		if (st_r.sel_s2) begin
			src = st_r.ser_word[`SAC_SR_ATT_HI:`SAC_SR_ATT_LO];
		end else begin
			src = st_r.par_s2;
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;

		// two-flop synchronisers for the parallel, gate, select and preset pins
		st_nxt.par_s1  = par_word;
		st_nxt.par_s2  = st_r.par_s1;
		st_nxt.gate_s1 = gate_pin;
		st_nxt.gate_s2 = st_r.gate_s1;
		st_nxt.sel_s1  = i_interface_select;
		st_nxt.sel_s2  = st_r.sel_s1;
		st_nxt.pre_s1  = {i_startup_preset_sel_b, i_startup_preset_sel_a};
		st_nxt.pre_s2  = st_r.pre_s1;

		// toggle crossing; the word is sampled only once the toggle
		// edge is seen, by then it has been stable for two cycles
		st_nxt.tog_t1 = link.tog;
		st_nxt.tog_t2 = st_r.tog_t1;
		st_nxt.tog_t3 = st_r.tog_t2;

		case (st_r.state)
			sac_pkg::SAC_SETTLE: begin
				// wait for synchronisers; stale toggles are dropped here
				if (!settle_end) begin
					st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
				end else begin
					st_nxt.state = sac_pkg::SAC_RUN;
					st_nxt.run   = 1'h1;
					if (st_r.sel_s2) begin
						// serial power-up copies the parallel pin levels
						st_nxt.ser_word = {st_r.par_s2, `SAC_EO_ZERO};
						st_nxt.atten    = st_r.par_s2;
					end else if (!st_r.gate_s2) begin
						st_nxt.atten = preset;
					end else begin
						st_nxt.atten = st_r.par_s2;
					end
				end
			end
			sac_pkg::SAC_RUN: begin
				// each shift lands a fresh word, independent of the gate
				if (tog_edge) begin
					st_nxt.ser_word = link.sr_word;
				end
				// transparent while gate high, holds while it is low
				if (st_r.gate_s2) begin
					st_nxt.atten = src;
				end
			end
			default: begin
				st_nxt.state      = sac_pkg::SAC_SETTLE;
				st_nxt.settle_cnt = 2'h0;
				st_nxt.run        = 1'h0;
			end
		endcase

		// update rate monitor: the host owns the rate, this only reports
		if (st_r.run && (st_nxt.atten != st_r.atten)) begin
			st_nxt.fast = (st_r.gap < `SAC_UPDATE_CYC);
			st_nxt.gap  = '0;
		end else if (st_r.gap != {`SAC_GAP_W{1'b1}}) begin
			st_nxt.gap = st_r.gap + `SAC_GAP_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	// reset doubles as power-up; gap starts saturated so the first
	// change is never flagged as too fast
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st_r     <= '0;
			st_r.gap <= {`SAC_GAP_W{1'b1}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_atten       = st_r.atten;
	assign o_serial_word = st_r.ser_word;
	assign o_ready       = st_r.run;
	assign o_fast_update = st_r.fast;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_serial_transparent;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && st_r.sel_s2 && st_r.gate_s2)
			|=> st_r.atten == $past(st_r.ser_word[`SAC_SR_ATT_HI:`SAC_SR_ATT_LO]);
	endproperty
	a_serial_transparent: assert property (p_serial_transparent)
		else $error("serial word not applied while gate high");

	property p_parallel_direct;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && !st_r.sel_s2 && st_r.gate_s2) |=> st_r.atten == $past(st_r.par_s2);
	endproperty
	a_parallel_direct: assert property (p_parallel_direct)
		else $error("parallel word not applied while gate high");

	property p_gate_low_holds;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && !st_r.gate_s2) |=> $stable(st_r.atten);
	endproperty
	a_gate_low_holds: assert property (p_gate_low_holds)
		else $error("attenuation changed while gate low");

	property p_pulse_captures;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && !st_r.sel_s2 && st_r.gate_s2 ##1 !st_r.gate_s2)
			|-> st_r.atten == $past(st_r.par_s2);
	endproperty
	a_pulse_captures: assert property (p_pulse_captures)
		else $error("capture pulse did not latch the parallel word");

	property p_preset;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && !st_r.gate_s2) |=> st_r.atten == $past(preset);
	endproperty
	a_preset: assert property (p_preset)
		else $error("power-up preset not applied");

	property p_preset_31;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && !st_r.gate_s2 && st_r.pre_s2 == 2'h3)
			|=> st_r.atten == 5'h1f;
	endproperty
	a_preset_31: assert property (p_preset_31)
		else $error("both preset selects high did not give 31 db");

	property p_preset_8;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && !st_r.gate_s2 && st_r.pre_s2 == 2'h2)
			|=> st_r.atten == 5'h08;
	endproperty
	a_preset_8: assert property (p_preset_8)
		else $error("select b alone did not give 8 db");

	property p_preset_16;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && !st_r.gate_s2 && st_r.pre_s2 == 2'h1)
			|=> st_r.atten == 5'h10;
	endproperty
	a_preset_16: assert property (p_preset_16)
		else $error("select a alone did not give 16 db");

	property p_preset_ref;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && !st_r.gate_s2 && st_r.pre_s2 == 2'h0)
			|=> st_r.atten == 5'h00;
	endproperty
	a_preset_ref: assert property (p_preset_ref)
		else $error("both preset selects low did not give reference loss");

	property p_gate_high_start;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && !st_r.sel_s2 && st_r.gate_s2) |=> st_r.atten == $past(st_r.par_s2);
	endproperty
	a_gate_high_start: assert property (p_gate_high_start)
		else $error("gate high power-up did not use parallel pins");

	property p_serial_start;
		@(posedge i_clk) disable iff (!i_rst_b)
		(settle_end && st_r.sel_s2)
			|=> (st_r.ser_word == {$past(st_r.par_s2), 1'b0}) && st_r.run;
	endproperty
	a_serial_start: assert property (p_serial_start)
		else $error("serial power-up did not copy the parallel pins");

	property p_ready_time;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(i_rst_b) |-> ##4 st_r.run;
	endproperty
	a_ready_time: assert property (p_ready_time)
		else $error("power-up settle took the wrong number of cycles");

	property p_pullup;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!i_word_capture_gate_en)[*3] |-> st_r.gate_s2;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("undriven gate did not read high");

	property p_word_lands;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && tog_edge) |=> st_r.ser_word == $past(link.sr_word);
	endproperty
	a_word_lands: assert property (p_word_lands)
		else $error("shifted word did not reach the core");

	property p_fast_flag;
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_r.run && st_nxt.atten != st_r.atten && st_r.gap < `SAC_UPDATE_CYC)
			|=> o_fast_update;
	endproperty
	a_fast_flag: assert property (p_fast_flag)
		else $error("too-fast update was not flagged");

endmodule // sac_top
